// >>> include/ctcm_defines.svh
// Register offsets, field positions and reset values of the counter/timer pair.
// Assumes byte addressing of the register port, one aligned 32-bit word per register.
`ifndef CTCM_DEFINES_SVH
`define CTCM_DEFINES_SVH

// Address bit choosing the unit, and the per-unit offset field
`define CTCM_UNIT_BIT 7
`define CTCM_OFS_MSB 6

// Per-unit register byte offsets
`define CTCM_REG_CTRL 7'h00
`define CTCM_REG_COUNT 7'h04
`define CTCM_REG_PRE_LIMIT 7'h08
`define CTCM_REG_PRE_COUNT 7'h0c
`define CTCM_REG_MATCH_CTRL 7'h10
`define CTCM_REG_CAP_CTRL 7'h14
`define CTCM_REG_OUT_CTRL 7'h18
`define CTCM_REG_INT_STATUS 7'h1c
`define CTCM_REG_INT_MASK 7'h20
`define CTCM_REG_MATCH0 7'h24
`define CTCM_REG_MATCH1 7'h28
`define CTCM_REG_MATCH2 7'h2c
`define CTCM_REG_MATCH3 7'h30
`define CTCM_REG_CAP0 7'h34
`define CTCM_REG_CAP1 7'h38

// Control register fields
`define CTCM_CTRL_EN 0
`define CTCM_CTRL_RST 1
`define CTCM_CTRL_MODE_LSB 2
`define CTCM_CTRL_SEL 4

// Capture control fields: channel c edge enables at 2c (rise) and 2c+1 (fall)
`define CTCM_CAP_CLR_EN 4
`define CTCM_CAP_CLR_SEL 5

// Interrupt status layout: match flags low, capture flags above
`define CTCM_INT_CAP_LSB 4

// Reset values
`define CTCM_RST_WORD 32'h0000_0000
`define CTCM_RST_CTRL 5'h00
`define CTCM_RST_FLAGS 6'h00

`endif

// >>> include/ctcm_pkg.sv
// Types shared by the counter/timer pair: bus carrier and mode encodings.
// Assumes the defines header is compiled alongside.
`default_nettype none

package ctcm_pkg;

  // Register port request, all fields from the bus master's clock domain
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ctcm_bus_req_type;

  // What drives the prescaler
  typedef enum logic [1:0] {
    CTCM_MODE_TIMER = 2'b00,
    CTCM_MODE_RISE = 2'b01,
    CTCM_MODE_FALL = 2'b10,
    CTCM_MODE_BOTH = 2'b11
  } ctcm_mode_type;

  // Action on a match output pin
  typedef enum logic [1:0] {
    CTCM_OUT_NONE = 2'b00,
    CTCM_OUT_LOW = 2'b01,
    CTCM_OUT_HIGH = 2'b10,
    CTCM_OUT_TOGGLE = 2'b11
  } ctcm_out_type;

endpackage

`default_nettype wire

// >>> rtl/ctcm_timer.sv
// Two 32-bit counter/timer units with prescaler, two captures, four matches each.
// Assumes capture pins are asynchronous and the register master shares clk_sys.
`include "ctcm_defines.svh"
`default_nettype none

// How it works
// - Two units, 32-bit counter behind 32-bit prescaler
// - Timer mode counts clocks; counter mode counts edges
// - Two captures copy count on selected edge
// - Chosen capture clears counter and prescaler
// - Four match registers; count runs through matches
// - Stop-on-match halts counter
// - Reset-on-match returns counter to zero
// - Two match pins: low, high, toggle, none
// - Match when match value equals count
// - Matches zero and one raise DMA requests
// - Each capture pin feeds exactly one channel
// - Capture input selectable as counting clock
module ctcm_timer
  import ctcm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire ctcm_bus_req_type busReq,
  output logic [31:0] readData,
  input wire logic [3:0] capIn,
  output logic [3:0] matchOut,
  output logic [3:0] dmaReq,
  output logic [1:0] irq
);

  localparam int UNITS = 2;

  logic [31:0] unitRead [UNITS]; // Per-unit read mux result
  logic [6:0] ofs; // Offset inside a unit
  logic unitSel; // Unit addressed by the bus

  assign ofs = busReq.addr[`CTCM_OFS_MSB:0];
  assign unitSel = busReq.addr[`CTCM_UNIT_BIT];

  // Read data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readData <= `CTCM_RST_WORD;
    end else if (ce) begin
      if (busReq.rd) begin
        readData <= unitRead[unitSel];
      end else begin
        readData <= `CTCM_RST_WORD;
      end
    end
  end

  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : gUnit
      logic wrHit; // Write aimed at this unit
      logic enable; // Counter running
      logic cntReset; // Counter and prescaler held at zero
      ctcm_mode_type mode; // Count source
      logic cntSel; // Capture pin used as counting clock
      logic [31:0] count; // timer_count_value
      logic [31:0] preLimit; // Prescaler wrap value
      logic [31:0] preCount; // Prescaler state
      logic [7:0] matchCtrl; // Per match: bit 2m reset, 2m+1 stop
      logic [5:0] capCtrl; // Edge enables, clear enable, clear channel
      logic [3:0] outAct; // Two action fields for the match pins
      logic [1:0] outLvl; // Match pin levels
      logic [5:0] status; // Sticky event flags
      logic [5:0] mask; // Interrupt enables
      logic [31:0] matchVal [4]; // Match registers
      logic [31:0] capVal [2]; // Capture registers
      logic [1:0] sync1; // First synchroniser stage, read by sync2 only
      logic [1:0] sync2; // Synchronised capture pins
      logic [1:0] sync3; // Previous synchronised value
      logic [1:0] rise; // Rising edges seen
      logic [1:0] fall; // Falling edges seen
      logic [1:0] capEv; // Capture events
      logic cntEdge; // Edge on the counting pin
      logic advance; // One count event for the prescaler
      logic tick; // Prescaler wraps, counter steps
      logic [3:0] hit; // Match events
      logic anyReset; // Some hit asks for reset
      logic anyStop; // Some hit asks for stop
      logic capClear; // Capture event clears the count

      assign wrHit = busReq.wr && (unitSel == 1'(u));

      // Pin capture synchroniser; pins are outside the clock domain
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1 <= 2'h0;
          sync2 <= 2'h0;
          sync3 <= 2'h0;
        end else if (ce) begin
          sync1 <= capIn[2*u +: 2];
          sync2 <= sync1;
          sync3 <= sync2;
        end
      end

      assign rise = sync2 & ~sync3;
      assign fall = ~sync2 & sync3;

      // Edge selection per channel
      genvar c;
      for (c = 0; c < 2; c++) begin : gCap
        assign capEv[c] = (capCtrl[2*c] && rise[c]) || (capCtrl[2*c+1] && fall[c]);
      end

      // Counter mode takes edges of the chosen pin instead of clocks
      always_comb begin
        case (mode)
          CTCM_MODE_RISE: cntEdge = rise[cntSel];
          CTCM_MODE_FALL: cntEdge = fall[cntSel];
          CTCM_MODE_BOTH: cntEdge = rise[cntSel] || fall[cntSel];
          default: cntEdge = 1'b1; // Timer mode: every clock
        endcase
      end

      assign advance = enable && !cntReset && cntEdge;
      assign tick = advance && (preCount == preLimit);

      // Match comparison on the step out of the matching value
      genvar m;
      for (m = 0; m < 4; m++) begin : gMatch
        assign hit[m] = tick && (count == matchVal[m]);
      end

      assign anyReset = |(hit & {matchCtrl[6], matchCtrl[4], matchCtrl[2], matchCtrl[0]});
      assign anyStop = |(hit & {matchCtrl[7], matchCtrl[5], matchCtrl[3], matchCtrl[1]});
      assign capClear = capCtrl[`CTCM_CAP_CLR_EN] && capEv[capCtrl[`CTCM_CAP_CLR_SEL]];

      // Control register; a stop hit clears the run bit unless the register is written that cycle
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          enable <= 1'b0;
          cntReset <= 1'b0;
          mode <= CTCM_MODE_TIMER;
          cntSel <= 1'b0;
        end else if (ce) begin
          if (wrHit && ofs == `CTCM_REG_CTRL) begin
            enable <= busReq.wdata[`CTCM_CTRL_EN];
            cntReset <= busReq.wdata[`CTCM_CTRL_RST];
            mode <= ctcm_mode_type'(busReq.wdata[`CTCM_CTRL_MODE_LSB +: 2]);
            cntSel <= busReq.wdata[`CTCM_CTRL_SEL];
          end else if (anyStop) begin
            enable <= 1'b0;
          end
        end
      end

      // Main counter; software write wins over hardware steps
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          count <= `CTCM_RST_WORD;
        end else if (ce) begin
          if (wrHit && ofs == `CTCM_REG_COUNT) begin
            count <= busReq.wdata;
          end else if (cntReset || capClear) begin
            count <= `CTCM_RST_WORD;
          end else if (anyReset) begin
            count <= `CTCM_RST_WORD;
          end else if (anyStop) begin
            count <= count;
          end else if (tick) begin
            count <= count + 32'h1;
          end
        end
      end

      // Prescaler: counts events, restarts after its limit
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          preCount <= `CTCM_RST_WORD;
        end else if (ce) begin
          if (cntReset || capClear) begin
            preCount <= `CTCM_RST_WORD;
          end else if (tick) begin
            preCount <= `CTCM_RST_WORD;
          end else if (advance) begin
            preCount <= preCount + 32'h1;
          end
        end
      end

      // Plain configuration registers
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          preLimit <= `CTCM_RST_WORD;
          matchCtrl <= 8'h00;
          capCtrl <= 6'h00;
          mask <= `CTCM_RST_FLAGS;
          for (int i = 0; i < 4; i++) begin
            matchVal[i] <= `CTCM_RST_WORD;
          end
        end else if (ce && wrHit) begin
          case (ofs)
            `CTCM_REG_PRE_LIMIT: preLimit <= busReq.wdata;
            `CTCM_REG_MATCH_CTRL: matchCtrl <= busReq.wdata[7:0];
            `CTCM_REG_CAP_CTRL: capCtrl <= busReq.wdata[5:0];
            `CTCM_REG_INT_MASK: mask <= busReq.wdata[5:0];
            `CTCM_REG_MATCH0: matchVal[0] <= busReq.wdata;
            `CTCM_REG_MATCH1: matchVal[1] <= busReq.wdata;
            `CTCM_REG_MATCH2: matchVal[2] <= busReq.wdata;
            `CTCM_REG_MATCH3: matchVal[3] <= busReq.wdata;
            default: preLimit <= preLimit; // Other offsets are written elsewhere or ignore writes
          endcase
        end
      end

      // Capture registers snapshot the count before any clear this cycle
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          capVal[0] <= `CTCM_RST_WORD;
          capVal[1] <= `CTCM_RST_WORD;
        end else if (ce) begin
          for (int i = 0; i < 2; i++) begin
            if (capEv[i]) begin
              capVal[i] <= count;
            end
          end
        end
      end

      // Match pins; a same-cycle software write loses to a hit
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          outAct <= 4'h0;
          outLvl <= 2'h0;
        end else if (ce) begin
          if (wrHit && ofs == `CTCM_REG_OUT_CTRL) begin
            outAct <= busReq.wdata[3:0];
          end
          for (int i = 0; i < 2; i++) begin
            if (hit[i]) begin
              case (ctcm_out_type'(outAct[2*i +: 2]))
                CTCM_OUT_LOW: outLvl[i] <= 1'b0;
                CTCM_OUT_HIGH: outLvl[i] <= 1'b1;
                CTCM_OUT_TOGGLE: outLvl[i] <= ~outLvl[i];
                default: outLvl[i] <= outLvl[i]; // Leave pin alone
              endcase
            end else if (wrHit && ofs == `CTCM_REG_OUT_CTRL) begin
              outLvl[i] <= busReq.wdata[4+i]; // Software presets the level
            end
          end
        end
      end

      // Sticky flags; a new event beats a same-cycle clear
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          status <= `CTCM_RST_FLAGS;
        end else if (ce) begin
          if (wrHit && ofs == `CTCM_REG_INT_STATUS) begin
            status <= (status & ~busReq.wdata[5:0]) | {capEv, hit};
          end else begin
            status <= status | {capEv, hit};
          end
        end
      end

      // DMA request pulses one cycle after a hit of match zero or one
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          dmaReq[2*u +: 2] <= 2'h0;
        end else if (ce) begin
          dmaReq[2*u +: 2] <= hit[1:0];
        end
      end

      assign matchOut[2*u +: 2] = outLvl;
      assign irq[u] = |(status & mask);

      // Read mux; unmapped offsets read zero
      always_comb begin
        case (ofs)
          `CTCM_REG_CTRL: unitRead[u] = {27'h0, cntSel, mode, cntReset, enable};
          `CTCM_REG_COUNT: unitRead[u] = count;
          `CTCM_REG_PRE_LIMIT: unitRead[u] = preLimit;
          `CTCM_REG_PRE_COUNT: unitRead[u] = preCount;
          `CTCM_REG_MATCH_CTRL: unitRead[u] = {24'h0, matchCtrl};
          `CTCM_REG_CAP_CTRL: unitRead[u] = {26'h0, capCtrl};
          `CTCM_REG_OUT_CTRL: unitRead[u] = {26'h0, outLvl, outAct};
          `CTCM_REG_INT_STATUS: unitRead[u] = {26'h0, status};
          `CTCM_REG_INT_MASK: unitRead[u] = {26'h0, mask};
          `CTCM_REG_MATCH0: unitRead[u] = matchVal[0];
          `CTCM_REG_MATCH1: unitRead[u] = matchVal[1];
          `CTCM_REG_MATCH2: unitRead[u] = matchVal[2];
          `CTCM_REG_MATCH3: unitRead[u] = matchVal[3];
          `CTCM_REG_CAP0: unitRead[u] = capVal[0];
          `CTCM_REG_CAP1: unitRead[u] = capVal[1];
          default: unitRead[u] = `CTCM_RST_WORD;
        endcase
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> sim/ctcm_timer_props.sv
// Port checker for the counter/timer pair: bus answers, pin causes, freeze.
// Assumes it is bound to ctcm_timer and sees only that module's ports.
`include "ctcm_defines.svh"
`default_nettype none

module ctcm_timer_props
  import ctcm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire ctcm_bus_req_type busReq,
  input wire logic [31:0] readData,
  input wire logic [3:0] capIn,
  input wire logic [3:0] matchOut,
  input wire logic [3:0] dmaReq,
  input wire logic [1:0] irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Accepted preset writes to each unit's pin control
  logic outWr0;
  logic outWr1;
  assign outWr0 = ce && busReq.wr && busReq.addr == {1'b0, `CTCM_REG_OUT_CTRL};
  assign outWr1 = ce && busReq.wr && busReq.addr == {1'b1, `CTCM_REG_OUT_CTRL};

  read_idle_a: assert property (ce && !busReq.rd |=> readData == 32'h0)
    else $error("read data outside its slot");
  unmapped_zero_a: assert property (ce && busReq.rd && busReq.addr[6:0] > 7'h38
    |=> readData == 32'h0)
    else $error("unmapped read not zero");
  ce_freeze_a: assert property (!ce |=> $stable(matchOut) && $stable(dmaReq)
    && $stable(readData))
    else $error("outputs moved while frozen");
  reset_quiet_a: assert property ($fell(rst) |-> readData == 32'h0 && matchOut == 4'h0
    && dmaReq == 4'h0 && irq == 2'h0)
    else $error("outputs not idle after reset");
  // Pin moves only on its own match or a preset write
  pin_cause_a: assert property ($changed(matchOut[0]) |-> dmaReq[0] || $past(outWr0))
    else $error("unit zero pin moved without cause");
  pin_one_cause_a: assert property ($changed(matchOut[3]) |-> dmaReq[3] || $past(outWr1))
    else $error("unit one pin moved without cause");
  preset_zero_a: assert property (outWr0 |=> (dmaReq[0] || matchOut[0] == $past(busReq.wdata[4]))
    && (dmaReq[1] || matchOut[1] == $past(busReq.wdata[5])))
    else $error("unit zero preset lost");
  preset_one_a: assert property (outWr1 |=> (dmaReq[2] || matchOut[2] == $past(busReq.wdata[4]))
    && (dmaReq[3] || matchOut[3] == $past(busReq.wdata[5])))
    else $error("unit one preset lost");

  cover property (dmaReq[0]);
  cover property ($rose(irq[0]));
  cover property ($rose(capIn[0]));
endmodule

bind ctcm_timer ctcm_timer_props i_props (.clk_sys, .rst, .ce, .busReq, .readData, .capIn,
  .matchOut, .dmaReq, .irq);

`default_nettype wire

// >>> sim/ctcm_pins.sv
// Pin-side model: drives the four capture pins as real inputs would.
// Assumes callers space level changes; each level holds five clocks for the sampler.
`default_nettype none

module ctcm_pins (
  input wire logic clk_sys,
  output logic [3:0] capIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins idle low
  initial capIn = 4'h0;
  // One level change, held past the two-flop sampler
  task automatic drive(input int ch, input logic v);
    @(posedge clk_sys);
    capIn[ch] <= v;
    repeat (5) @(posedge clk_sys);
  endtask
  // Full pulses on one pin
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      drive(ch, 1'b1);
      drive(ch, 1'b0);
    end
  endtask
endmodule

`default_nettype wire

// >>> sim/ctcm_timer_tb.sv
// Self-checking bench for the counter/timer pair through its register port.
// Assumes the checker binds itself and ctcm_pins plays the capture pins.
`include "ctcm_defines.svh"
`default_nettype none

module ctcm_timer_tb
  import ctcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Unit zero addresses
  localparam logic [7:0] CTRL = {1'b0, `CTCM_REG_CTRL};
  localparam logic [7:0] CNT = {1'b0, `CTCM_REG_COUNT};
  localparam logic [7:0] PLIM = {1'b0, `CTCM_REG_PRE_LIMIT};
  localparam logic [7:0] MCTL = {1'b0, `CTCM_REG_MATCH_CTRL};
  localparam logic [7:0] CCTL = {1'b0, `CTCM_REG_CAP_CTRL};
  localparam logic [7:0] OCTL = {1'b0, `CTCM_REG_OUT_CTRL};
  localparam logic [7:0] STAT = {1'b0, `CTCM_REG_INT_STATUS};
  localparam logic [7:0] MASK = {1'b0, `CTCM_REG_INT_MASK};
  localparam logic [7:0] M0 = {1'b0, `CTCM_REG_MATCH0};
  localparam logic [7:0] CAP0 = {1'b0, `CTCM_REG_CAP0};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  ctcm_bus_req_type req = '0;
  logic [31:0] readData;
  logic [3:0] capIn;
  logic [3:0] matchOut;
  logic [3:0] dmaReq;
  logic [1:0] irq;
  logic [31:0] rv; // Last read word
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int t0;

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  ctcm_timer i_dut (.clk_sys, .rst, .ce, .busReq(req), .readData, .capIn, .matchOut,
    .dmaReq, .irq);
  ctcm_pins i_pins (.clk_sys, .capIn);

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask
  // Read word lands in the cycle after the strobe only
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 rv = readData;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for a DMA pulse
  task automatic wdma(input int b);
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      #1;
      if (dmaReq[b] === 1'b1) break;
    end
    chk("dma pulse", 32'h1, {31'h0, dmaReq[b]});
  endtask
  task automatic wrap_up();
    $display("Counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cycle count and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    ce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ce <= 1'b1;
    // Every register of both units starts at zero
    for (int u = 0; u < 2; u++) begin
      for (int o = 0; o < 60; o += 4) begin
        rd({u[0], o[6:0]});
        chk("reset value", 32'h0, rv);
      end
    end
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c);
    chk("unmapped", 32'h0, rv);
    $display("Test reset values done");
    // Each pin action, mask on and off
    wr(M0, 32'h2);
    for (int a = 0; a < 4; a++) begin
      wr(CTRL, 32'h2);
      wr(OCTL, {a[0], 2'b00, a[1:0]});
      wr(STAT, 32'h3f);
      wr(MASK, {31'h0, a[0]});
      wr(CTRL, 32'h1);
      wdma(0);
      chk("match pin", {31'h0, a == 2}, {31'h0, matchOut[0]});
      chk("irq", {31'h0, a[0]}, {31'h0, irq[0]});
      rd(STAT);
      chk("status", 32'hf, rv);
      wr(STAT, 32'h1);
      rd(STAT);
      chk("status clear", 32'he, rv);
    end
    $display("Test match actions done");
    // Clock enable low must hold a running count still
    wr(CTRL, 32'h2);
    wr(CTRL, 32'h1);
    ce <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ce <= 1'b1;
    rd(CNT);
    chk("frozen count", 32'h1, rv);
    $display("Test freeze done");
    // Stop on match; match one hits first as it holds zero
    wr(CTRL, 32'h2);
    wr(MCTL, 32'h2);
    wr(CTRL, 32'h1);
    wdma(1);
    wdma(0);
    repeat (3) @(posedge clk_sys);
    rd(CNT);
    chk("stopped count", 32'h2, rv);
    rd(CTRL);
    chk("enable cleared", 32'h0, rv);
    $display("Test stop done");
    // Reset on match, plain and prescaled
    for (int j = 0; j < 2; j++) begin
      wr(CTRL, 32'h2);
      wr(MCTL, 32'h1);
      wr(PLIM, j ? 32'h2 : 32'h0);
      wr(M0, j ? 32'h1 : 32'h3);
      wr(CTRL, 32'h1);
      wdma(0);
      t0 = cyc;
      wdma(0);
      chk("match period", j ? 32'd6 : 32'd4, cyc - t0);
    end
    $display("Test reset on match done");
    // Pin-driven counting, capture, clear on capture
    wr(CTRL, 32'h2);
    wr(MCTL, 32'h0);
    wr(PLIM, 32'h0);
    wr(CCTL, 32'h1);
    wr(CTRL, 32'h15);
    i_pins.pulse(1, 5);
    rd(CNT);
    chk("edge count", 32'h5, rv);
    i_pins.drive(0, 1'b1);
    rd(CAP0);
    chk("capture", 32'h5, rv);
    rd(STAT);
    chk("capture flag", 32'h1, {31'h0, rv[4]});
    wr(CCTL, 32'h12);
    i_pins.pulse(1, 3);
    i_pins.drive(0, 1'b0);
    rd(CAP0);
    chk("capture falling", 32'h8, rv);
    rd(CNT);
    chk("cleared count", 32'h0, rv);
    // Falling edges only, then both edges with channel one clearing
    wr(CTRL, 32'h19);
    i_pins.pulse(1, 2);
    rd(CNT);
    chk("falling count", 32'h2, rv);
    wr(CCTL, 32'h34);
    wr(CTRL, 32'h1d);
    i_pins.pulse(1, 2);
    rd({1'b0, `CTCM_REG_CAP1});
    chk("capture one", 32'h1, rv);
    rd(CNT);
    chk("both edges", 32'h1, rv);
    $display("Test capture done");
    // Unit one pin preset
    wr({1'b1, `CTCM_REG_OUT_CTRL}, 32'h2c);
    #1;
    chk("unit one pin", 32'h1, {31'h0, matchOut[3]});
    // Unit one: zero matches hit on the first step, pin one toggles
    wr({1'b1, `CTCM_REG_INT_MASK}, 32'h2);
    wr({1'b1, `CTCM_REG_CTRL}, 32'h1);
    wdma(3);
    chk("unit one toggle", 32'h0, {31'h0, matchOut[3]});
    chk("unit one irq", 32'h1, {31'h0, irq[1]});
    $display("Test unit one done");
    wrap_up();
  end
endmodule

`default_nettype wire
